// ---- rtl/fcl_pkg.sv ----
// package: constants, map and state type for the fuse configuration loader
package fcl_pkg;
	// block sizes
	localparam int NUM_CONV = 2;
	localparam int CFG_BYTES = 6;
	localparam int SLOT_W = 4;
	localparam int TMR_W = 24;
	// live register map
	localparam logic [7:0] ADDR_B1_START = 8'h40;
	localparam logic [7:0] ADDR_B1_MODE = 8'h41;
	localparam logic [7:0] ADDR_B1_LEVEL = 8'h42;
	localparam logic [7:0] ADDR_B2_START = 8'h43;
	localparam logic [7:0] ADDR_B2_MODE = 8'h44;
	localparam logic [7:0] ADDR_CONV_SEL = 8'h50;
	localparam logic [7:0] ADDR_PROG_CTRL = 8'h51;
	localparam int IDX_CONV_SEL = 5;
	// program control field layout
	localparam int PROG_REQ_BIT = 0;
	localparam int CSUM_ERR_BIT = 1;
	localparam int BURN_CNT_LSB = 2;
	localparam int BURN_CNT_MSB = 3;
	localparam logic [1:0] MAX_BURNS = 2'h3;
	// fuse store slots beyond the configuration bytes
	localparam logic [SLOT_W-1:0] SLOT_CSUM_LO = 4'h6;
	localparam logic [SLOT_W-1:0] SLOT_CSUM_HI = 4'h7;
	localparam logic [SLOT_W-1:0] SLOT_COUNT = 4'h8;
	// hard-coded defaults, byte 0 in the low bits
	localparam logic [CFG_BYTES*8-1:0] DEF_CFG = 48'h03_1C_41_1C_1C_41;
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int OPER_DELAY_US = 100;
	localparam int BURN_HOLD_MS = 100;
	localparam int STAGGER_US = 1000;
	localparam int OPER_DELAY_CYC = OPER_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int BURN_HOLD_CYC = BURN_HOLD_MS * (CLK_HZ / 1_000);
	localparam int STAGGER_CYC = STAGGER_US * (CLK_HZ / 1_000_000);
	// controller states
	typedef enum logic [3:0] {
		FCL_WAIT_VCC = 4'h0,
		FCL_DELAY = 4'h1,
		FCL_LOAD = 4'h2,
		FCL_CHECK = 4'h3,
		FCL_IDLE = 4'h4,
		FCL_BURN_CHK = 4'h5,
		FCL_BURN_WR = 4'h6,
		FCL_BURN_HOLD = 4'h7,
		FCL_RESTART = 4'h8
	} fcl_state_t;
endpackage : fcl_pkg

// ---- rtl/fcl_csum_if.sv ----
// interface: checksum engine control and result
`timescale 1ns/1ps
interface fcl_csum_if;
	logic clr;
	logic add;
	logic [7:0] data;
	logic [15:0] sum;
	modport ctrl (output clr, output add, output data, input sum);
	modport eng (input clr, input add, input data, output sum);
endinterface : fcl_csum_if

// ---- rtl/fcl_csum.sv ----
// module: 16-bit rotate-and-add checksum engine
`timescale 1ns/1ps
module fcl_csum (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// control and result
	fcl_csum_if.eng cs
);
	logic [15:0] sum_ff;
	logic [15:0] nxt_sum;
	logic [15:0] base;

	// same function for burn and power-up check
	always_comb begin
		base = cs.clr ? 16'h0000 : {sum_ff[14:0], sum_ff[15]};
		if (cs.add) begin
			nxt_sum = base + {8'h00, cs.data};
		end else if (cs.clr) begin
			nxt_sum = 16'h0000;
		end else begin
			nxt_sum = sum_ff;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sum_ff <= 16'h0000;
		end else begin
			sum_ff <= nxt_sum;
		end
	end

	assign cs.sum = sum_ff;
endmodule : fcl_csum

// ---- rtl/fcl_loader.sv ----
// module: fuse store loader, burn sequencer and live register file
// Function
// - port and fuse logic live 100us after supply
// - enabled start runs only fuse-selected converters
// - copy fuse store to live registers once
// - enable toggling never reloads from fuse store
// - fuse store accepts at most three burns
// - live register writes act at once, volatile
// - converters off during burn, restart one by one
// - request bit starts burn, writes locked, reads served
// - low programming supply at burn request aborts burn and unlocks
// - burn stores 16-bit checksum with the data
// - request bit cleared and unlock after 100ms
// - power-up checksum match on a burned store loads data, else defaults
// - checksum mismatch on a burned store sets readable error flag
// - live registers accessible while converters run
`timescale 1ns/1ps
module fcl_loader #(
	parameter int OPER_DELAY = fcl_pkg::OPER_DELAY_CYC,
	parameter int BURN_HOLD = fcl_pkg::BURN_HOLD_CYC,
	parameter int STAGGER = fcl_pkg::STAGGER_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// supply and pin status
	input wire logic vcc_good_i,
	input wire logic prog_supply_ok_i,
	input wire logic enable_sync_input_i,
	// host register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_wr_refused_o,
	// fuse store port
	output logic fuse_rd_o,
	output logic fuse_wr_o,
	output logic [fcl_pkg::SLOT_W-1:0] fuse_addr_o,
	output logic [7:0] fuse_wdata_o,
	input wire logic [7:0] fuse_rdata_i,
	input wire logic fuse_ack_i,
	// converter side
	output logic [fcl_pkg::CFG_BYTES*8-1:0] cfg_o,
	output logic [fcl_pkg::NUM_CONV-1:0] conv_en_o,
	output logic ready_o,
	output logic program_request_bit_o
);
	import fcl_pkg::*;

	localparam int STAGE_W = $clog2(NUM_CONV + 1);

	fcl_state_t state_ff, nxt_state;
	logic [SLOT_W-1:0] idx_ff, nxt_idx;
	logic [TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [STAGE_W-1:0] stage_ff, nxt_stage;
	logic [7:0] cfg_ff [CFG_BYTES];
	logic [7:0] nxt_cfg [CFG_BYTES];
	logic [7:0] fbuf_ff [CFG_BYTES];
	logic [7:0] nxt_fbuf [CFG_BYTES];
	logic [15:0] csum_rd_ff, nxt_csum_rd;
	logic [1:0] burn_cnt_ff, nxt_burn_cnt;
	logic prog_ff, nxt_prog;
	logic err_ff, nxt_err;
	logic ready_ff, nxt_ready;
	logic [7:0] rdata_ff, nxt_rdata;
	logic refused_ff, nxt_refused;
	logic [7:0] wdata_ff, nxt_wdata;
	logic [NUM_CONV-1:0] conv_en_ff, nxt_conv_en;
	logic burning;
	logic wr_hit;
	logic [SLOT_W-1:0] wr_idx;
	logic [SLOT_W-1:0] idx_next;

	fcl_csum_if cs ();

	fcl_csum u_csum (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.cs(cs)
	);

	// live register address to array index
	function automatic logic [SLOT_W:0] cfg_decode(input logic [7:0] addr);
		case (addr)
			ADDR_B1_START: cfg_decode = {1'b1, 4'h0};
			ADDR_B1_MODE: cfg_decode = {1'b1, 4'h1};
			ADDR_B1_LEVEL: cfg_decode = {1'b1, 4'h2};
			ADDR_B2_START: cfg_decode = {1'b1, 4'h3};
			ADDR_B2_MODE: cfg_decode = {1'b1, 4'h4};
			ADDR_CONV_SEL: cfg_decode = {1'b1, SLOT_W'(IDX_CONV_SEL)};
			default: cfg_decode = {1'b0, 4'h0};
		endcase
	endfunction : cfg_decode

	assign {wr_hit, wr_idx} = cfg_decode(reg_addr_i);
	assign idx_next = idx_ff + 4'h1;
	// burning keeps converters down until the restart stage releases them
	assign burning = (state_ff == FCL_BURN_WR) || (state_ff == FCL_BURN_HOLD);

	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_tmr = tmr_ff;
		nxt_stage = stage_ff;
		nxt_cfg = cfg_ff;
		nxt_fbuf = fbuf_ff;
		nxt_csum_rd = csum_rd_ff;
		nxt_burn_cnt = burn_cnt_ff;
		nxt_prog = prog_ff;
		nxt_err = err_ff;
		nxt_ready = ready_ff;
		nxt_wdata = wdata_ff;
		nxt_refused = 1'b0;
		nxt_rdata = rdata_ff;
		cs.clr = 1'b0;
		cs.add = 1'b0;
		cs.data = fuse_rdata_i;
		fuse_rd_o = 1'b0;
		fuse_wr_o = 1'b0;

		// reads always served once the port is live
		if (reg_rd_i && ready_ff) begin
			if (wr_hit) begin
				nxt_rdata = cfg_ff[wr_idx[2:0]];
			end else if (reg_addr_i == ADDR_PROG_CTRL) begin
				nxt_rdata = 8'h00;
				nxt_rdata[PROG_REQ_BIT] = prog_ff;
				nxt_rdata[CSUM_ERR_BIT] = err_ff;
				nxt_rdata[BURN_CNT_MSB:BURN_CNT_LSB] = burn_cnt_ff;
			end else begin
				nxt_rdata = 8'h00;
			end
		end

		// writes land immediately unless the burn lock holds
		if (reg_wr_i && ready_ff) begin
			if (prog_ff) begin
				nxt_refused = 1'b1;
			end else if (wr_hit) begin
				nxt_cfg[wr_idx[2:0]] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_PROG_CTRL && reg_wdata_i[PROG_REQ_BIT]
					&& state_ff == FCL_IDLE) begin
				nxt_prog = 1'b1;
				nxt_state = FCL_BURN_CHK;
			end
		end

		case (state_ff)
			FCL_WAIT_VCC: begin
				if (vcc_good_i) begin
					nxt_tmr = '0;
					nxt_state = FCL_DELAY;
				end
			end
			FCL_DELAY: begin
				// independent of the enable pin
				if (tmr_ff == TMR_W'(OPER_DELAY - 1)) begin
					nxt_idx = '0;
					cs.clr = 1'b1;
					nxt_state = FCL_LOAD;
				end else begin
					nxt_tmr = tmr_ff + 24'h000001;
				end
			end
			FCL_LOAD: begin
				fuse_rd_o = 1'b1;
				if (fuse_ack_i) begin
					if (idx_ff < SLOT_W'(CFG_BYTES)) begin
						nxt_fbuf[idx_ff[2:0]] = fuse_rdata_i;
						cs.add = 1'b1;
					end else if (idx_ff == SLOT_CSUM_LO) begin
						nxt_csum_rd[7:0] = fuse_rdata_i;
					end else if (idx_ff == SLOT_CSUM_HI) begin
						nxt_csum_rd[15:8] = fuse_rdata_i;
					end else begin
						nxt_burn_cnt = fuse_rdata_i[1:0];
					end
					if (idx_ff == SLOT_COUNT) begin
						nxt_state = FCL_CHECK;
					end else begin
						nxt_idx = idx_next;
					end
				end
			end
			FCL_CHECK: begin
				// a blank store is not an error, it simply uses defaults
				if (burn_cnt_ff != 2'h0 && cs.sum == csum_rd_ff) begin
					nxt_cfg = fbuf_ff;
				end else begin
					for (int i = 0; i < CFG_BYTES; i++) begin
						nxt_cfg[i] = DEF_CFG[i*8 +: 8];
					end
					nxt_err = (burn_cnt_ff != 2'h0);
				end
				nxt_ready = 1'b1;
				nxt_stage = STAGE_W'(NUM_CONV);
				nxt_state = FCL_IDLE;
			end
			FCL_IDLE: begin
				// no path back to loading, so enable toggles never reload
				nxt_state = nxt_state;
			end
			FCL_BURN_CHK: begin
				if (!prog_supply_ok_i || burn_cnt_ff == MAX_BURNS) begin
					nxt_prog = 1'b0;
					nxt_state = FCL_IDLE;
				end else begin
					nxt_idx = '0;
					cs.clr = 1'b1;
					cs.add = 1'b1;
					cs.data = cfg_ff[0];
					nxt_wdata = cfg_ff[0];
					nxt_state = FCL_BURN_WR;
				end
			end
			FCL_BURN_WR: begin
				fuse_wr_o = 1'b1;
				cs.data = cfg_ff[idx_next[2:0]];
				if (fuse_ack_i) begin
					if (idx_ff == SLOT_COUNT) begin
						nxt_burn_cnt = burn_cnt_ff + 2'h1;
						nxt_tmr = '0;
						nxt_state = FCL_BURN_HOLD;
					end else begin
						nxt_idx = idx_next;
						if (idx_next < SLOT_W'(CFG_BYTES)) begin
							cs.add = 1'b1;
							nxt_wdata = cfg_ff[idx_next[2:0]];
						end else if (idx_next == SLOT_CSUM_LO) begin
							nxt_wdata = cs.sum[7:0];
						end else if (idx_next == SLOT_CSUM_HI) begin
							nxt_wdata = cs.sum[15:8];
						end else begin
							nxt_wdata = {6'h00, burn_cnt_ff + 2'h1};
						end
					end
				end
			end
			FCL_BURN_HOLD: begin
				if (tmr_ff == TMR_W'(BURN_HOLD - 1)) begin
					nxt_prog = 1'b0;
					nxt_tmr = '0;
					nxt_stage = STAGE_W'(1);
					nxt_state = FCL_RESTART;
				end else begin
					nxt_tmr = tmr_ff + 24'h000001;
				end
			end
			FCL_RESTART: begin
				// one converter more per stagger period
				if (stage_ff == STAGE_W'(NUM_CONV)) begin
					nxt_state = FCL_IDLE;
				end else if (tmr_ff == TMR_W'(STAGGER - 1)) begin
					nxt_tmr = '0;
					nxt_stage = stage_ff + STAGE_W'(1);
				end else begin
					nxt_tmr = tmr_ff + 24'h000001;
				end
			end
			default: begin
				nxt_state = FCL_WAIT_VCC;
			end
		endcase
	end

	// per-converter enable: pin, fuse selection, restart stage, burn hold
	for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
		assign nxt_conv_en[g] = enable_sync_input_i && ready_ff && !burning
			&& cfg_ff[IDX_CONV_SEL][g] && (STAGE_W'(g) < stage_ff);
		assign cfg_o[g*8 +: 8] = cfg_ff[g];
	end
	for (genvar k = NUM_CONV; k < CFG_BYTES; k++) begin : g_cfg
		assign cfg_o[k*8 +: 8] = cfg_ff[k];
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= FCL_WAIT_VCC;
			idx_ff <= '0;
			tmr_ff <= '0;
			stage_ff <= '0;
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_ff[i] <= 8'h00;
				fbuf_ff[i] <= 8'h00;
			end
			csum_rd_ff <= 16'h0000;
			burn_cnt_ff <= 2'h0;
			prog_ff <= 1'b0;
			err_ff <= 1'b0;
			ready_ff <= 1'b0;
			rdata_ff <= 8'h00;
			refused_ff <= 1'b0;
			wdata_ff <= 8'h00;
			conv_en_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			tmr_ff <= nxt_tmr;
			stage_ff <= nxt_stage;
			cfg_ff <= nxt_cfg;
			fbuf_ff <= nxt_fbuf;
			csum_rd_ff <= nxt_csum_rd;
			burn_cnt_ff <= nxt_burn_cnt;
			prog_ff <= nxt_prog;
			err_ff <= nxt_err;
			ready_ff <= nxt_ready;
			rdata_ff <= nxt_rdata;
			refused_ff <= nxt_refused;
			wdata_ff <= nxt_wdata;
			conv_en_ff <= nxt_conv_en;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reg_wr_refused_o = refused_ff;
	assign fuse_addr_o = idx_ff;
	assign fuse_wdata_o = wdata_ff;
	assign conv_en_o = conv_en_ff;
	assign ready_o = ready_ff;
	assign program_request_bit_o = prog_ff;
endmodule : fcl_loader

// ---- testbench/fcl_fuse_model.sv ----
// model: fuse store behind the loader's fuse port
`timescale 1ns/1ps
module fcl_fuse_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// request side
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	// answer side
	output logic [7:0] rdata_o,
	output logic ack_o
);
	// contents survive reset, as a fuse store must
	logic [7:0] mem [0:8];
	int lat = 0;
	int cnt;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			cnt <= 0;
			rdata_o <= 8'h5A;
		end else if (ack_o || !(rd_i || wr_i)) begin
			// read data is only good with ack, so it toggles otherwise
			ack_o <= 1'b0;
			cnt <= 0;
			rdata_o <= ~rdata_o;
		end else if (cnt >= lat) begin
			ack_o <= 1'b1;
			rdata_o <= mem[addr_i];
			if (wr_i) mem[addr_i] <= wdata_i;
		end else begin
			cnt <= cnt + 1;
			rdata_o <= ~rdata_o;
		end
	end
endmodule : fcl_fuse_model

// ---- testbench/fcl_loader_properties.sv ----
// checker: concurrent properties on the loader ports
`timescale 1ns/1ps
module fcl_loader_properties #(
	parameter int OPER_DELAY = 10
) (
	// clock, reset and pins
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic vcc_good_i,
	input wire logic prog_supply_ok_i,
	input wire logic enable_sync_input_i,
	// host port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_wr_refused_o,
	// fuse port and outputs
	input wire logic fuse_rd_o,
	input wire logic fuse_wr_o,
	input wire logic [fcl_pkg::SLOT_W-1:0] fuse_addr_o,
	input wire logic [7:0] fuse_wdata_o,
	input wire logic fuse_ack_i,
	input wire logic [fcl_pkg::CFG_BYTES*8-1:0] cfg_o,
	input wire logic [fcl_pkg::NUM_CONV-1:0] conv_en_o,
	input wire logic ready_o,
	input wire logic program_request_bit_o
);
	import fcl_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// cycles with supply good, saturating so a long run cannot wrap
	logic [15:0] vcc_cnt_ff;
	logic [15:0] nxt_vcc_cnt;
	always_comb begin
		nxt_vcc_cnt = (vcc_cnt_ff == 16'hFFFF) ? vcc_cnt_ff : vcc_cnt_ff + 16'h0001;
		if (!vcc_good_i) nxt_vcc_cnt = 16'h0000;
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) vcc_cnt_ff <= 16'h0000;
		else vcc_cnt_ff <= nxt_vcc_cnt;
	end
	property p_ready_delay;
		$rose(ready_o) |-> vcc_cnt_ff > OPER_DELAY;
	endproperty
	a_ready_delay: assert property (p_ready_delay) else $error("ready too early");
	property p_conv_pin;
		!enable_sync_input_i ##1 !enable_sync_input_i |-> conv_en_o == 2'b00;
	endproperty
	a_conv_pin: assert property (p_conv_pin) else $error("converter on, pin low");
	property p_fuse_rd_hold;
		fuse_rd_o && !fuse_ack_i |=> fuse_rd_o && $stable(fuse_addr_o);
	endproperty
	a_fuse_rd_hold: assert property (p_fuse_rd_hold) else $error("fuse read dropped");
	property p_lock_refuse;
		ready_o && program_request_bit_o && reg_wr_i |=> reg_wr_refused_o && $stable(cfg_o);
	endproperty
	a_lock_refuse: assert property (p_lock_refuse) else $error("locked write taken");
	property p_refuse_cause;
		reg_wr_refused_o |-> $past(program_request_bit_o) && $past(reg_wr_i);
	endproperty
	a_refuse_cause: assert property (p_refuse_cause) else $error("stray refusal");
	property p_read_busy;
		ready_o && reg_rd_i && reg_addr_i == ADDR_PROG_CTRL
			|=> reg_rdata_o[PROG_REQ_BIT] == $past(program_request_bit_o);
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("busy bit misread");
	property p_abort;
		$rose(program_request_bit_o) && !prog_supply_ok_i |=> !program_request_bit_o && !fuse_wr_o;
	endproperty
	a_abort: assert property (p_abort) else $error("burn not aborted");
	property p_burn_conv_off;
		fuse_wr_o && $past(fuse_wr_o) |-> conv_en_o == 2'b00;
	endproperty
	a_burn_conv_off: assert property (p_burn_conv_off) else $error("converter on in burn");
	property p_fuse_wr_hold;
		fuse_wr_o && !fuse_ack_i |=> fuse_wr_o && $stable(fuse_wdata_o) && $stable(fuse_addr_o);
	endproperty
	a_fuse_wr_hold: assert property (p_fuse_wr_hold) else $error("fuse write dropped");
	property p_hold_time;
		fuse_wr_o && fuse_ack_i && fuse_addr_o == SLOT_COUNT |=> program_request_bit_o [*8];
	endproperty
	a_hold_time: assert property (p_hold_time) else $error("busy cleared early");
endmodule : fcl_loader_properties
bind fcl_loader fcl_loader_properties #(.OPER_DELAY(OPER_DELAY)) u_fcl_loader_properties (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .vcc_good_i(vcc_good_i),
	.prog_supply_ok_i(prog_supply_ok_i), .enable_sync_input_i(enable_sync_input_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_rdata_o(reg_rdata_o), .reg_wr_refused_o(reg_wr_refused_o), .fuse_rd_o(fuse_rd_o),
	.fuse_wr_o(fuse_wr_o), .fuse_addr_o(fuse_addr_o), .fuse_wdata_o(fuse_wdata_o),
	.fuse_ack_i(fuse_ack_i), .cfg_o(cfg_o), .conv_en_o(conv_en_o), .ready_o(ready_o),
	.program_request_bit_o(program_request_bit_o));

// ---- testbench/tb_fcl_loader.sv ----
// testbench: scenarios for the fuse configuration loader
`timescale 1ns/1ps
module tb_fcl_loader;
	import fcl_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic vcc = 1'b0;
	logic sup = 1'b1;
	logic en = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdat, frd, fwd, v;
	logic refd, frq, fwq, fack, rdy, prog;
	logic [3:0] fa;
	logic [47:0] cfg, e;
	logic [1:0] cen;
	int fails = 0;
	int checked = 0;
	// short counts keep the run small
	fcl_loader #(.OPER_DELAY(10), .BURN_HOLD(20), .STAGGER(5)) u_fcl_loader (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .vcc_good_i(vcc), .prog_supply_ok_i(sup),
		.enable_sync_input_i(en), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_wr_refused_o(refd), .fuse_rd_o(frq),
		.fuse_wr_o(fwq), .fuse_addr_o(fa), .fuse_wdata_o(fwd), .fuse_rdata_i(frd),
		.fuse_ack_i(fack), .cfg_o(cfg), .conv_en_o(cen), .ready_o(rdy),
		.program_request_bit_o(prog));
	fcl_fuse_model u_fcl_fuse_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rd_i(frq),
		.wr_i(fwq), .addr_i(fa), .wdata_i(fwd), .rdata_o(frd), .ack_o(fack));
	initial forever #5 mclk_i = ~mclk_i;
	task automatic chk(input string n, input logic [47:0] s, input logic [47:0] x);
		checked++;
		if (s !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge mclk_i);
		wr = 1'b0;
	endtask : wrr
	task automatic rdr(input logic [7:0] a);
		@(negedge mclk_i);
		rd = 1'b1;
		addr = a;
		@(negedge mclk_i);
		rd = 1'b0;
		v = rdat;
	endtask : rdr
	task automatic pwr();
		rst_n_i = 1'b0;
		vcc = 1'b0;
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1'b1;
		vcc = 1'b1;
		for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge mclk_i);
		chk("ready", rdy, 1'b1);
	endtask : pwr
	function automatic logic [15:0] csum(input logic [47:0] c);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < CFG_BYTES; i++) s = {s[14:0], s[15]} + {8'h00, c[i*8+:8]};
		return s;
	endfunction : csum
	task automatic t_boot();
		for (int i = 0; i < 9; i++) u_fcl_fuse_model.mem[i] = 8'h00;
		pwr();
		chk("defaults", cfg, DEF_CFG);
		rdr(ADDR_PROG_CTRL);
		chk("ctrl", v, 8'h00);
		repeat (20) @(negedge mclk_i);
		chk("conv on", cen, 2'b11);
		$display("test boot done");
	endtask : t_boot
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			wrr(ADDR_B1_START + i[7:0], 8'hA0 + i[7:0]);
			chk("live byte", cfg[i*8+:8], 8'hA0 + i[7:0]);
			rdr(ADDR_B1_START + i[7:0]);
			chk("read byte", v, 8'hA0 + i[7:0]);
		end
		wrr(ADDR_CONV_SEL, 8'h01);
		@(negedge mclk_i);
		chk("conv sel", cen, 2'b01);
		wrr(ADDR_CONV_SEL, 8'h03);
		rdr(8'h60);
		chk("unmapped", v, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_abort();
		sup = 1'b0;
		wrr(ADDR_PROG_CTRL, 8'h01);
		repeat (3) @(negedge mclk_i);
		chk("abort", prog, 1'b0);
		wrr(ADDR_B1_START, 8'h55);
		chk("unlocked", cfg[7:0], 8'h55);
		chk("no burn", u_fcl_fuse_model.mem[SLOT_COUNT], 8'h00);
		sup = 1'b1;
		$display("test abort done");
	endtask : t_abort
	task automatic t_burn();
		e = cfg;
		u_fcl_fuse_model.lat = 3;
		wrr(ADDR_PROG_CTRL, 8'h01);
		wrr(ADDR_B1_START, 8'hEE);
		chk("refused", refd, 1'b1);
		chk("kept", cfg, e);
		rdr(ADDR_B1_LEVEL);
		chk("locked read", v, e[23:16]);
		v = 8'h01;
		for (int i = 0; i < 200 && v[0] !== 1'b0; i++) rdr(ADDR_PROG_CTRL);
		chk("busy clear", v[0], 1'b0);
		for (int i = 0; i < 6; i++) chk("stored", u_fcl_fuse_model.mem[i], e[i*8+:8]);
		chk("csum", {u_fcl_fuse_model.mem[7], u_fcl_fuse_model.mem[6]}, csum(e));
		chk("count", u_fcl_fuse_model.mem[SLOT_COUNT], 8'h01);
		repeat (20) @(negedge mclk_i);
		chk("restart", cen, 2'b11);
		u_fcl_fuse_model.lat = 0;
		$display("test burn done");
	endtask : t_burn
	task automatic t_reload();
		pwr();
		chk("loaded", cfg, e);
		rdr(ADDR_PROG_CTRL);
		chk("ctrl", v, 8'h04);
		en = 1'b0;
		wrr(ADDR_B1_START, 8'h11);
		chk("pin off", cen, 2'b00);
		en = 1'b1;
		repeat (20) @(negedge mclk_i);
		chk("no reload", cfg[7:0], 8'h11);
		$display("test reload done");
	endtask : t_reload
	task automatic t_bad();
		u_fcl_fuse_model.mem[6] = u_fcl_fuse_model.mem[6] ^ 8'h01;
		u_fcl_fuse_model.mem[SLOT_COUNT] = 8'h03;
		pwr();
		chk("fallback", cfg, DEF_CFG);
		rdr(ADDR_PROG_CTRL);
		chk("err flag", v, 8'h0E);
		wrr(ADDR_PROG_CTRL, 8'h01);
		repeat (3) @(negedge mclk_i);
		chk("worn out", prog, 1'b0);
		chk("untouched", u_fcl_fuse_model.mem[0], e[7:0]);
		$display("test bad done");
	endtask : t_bad
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		t_boot();
		t_regs();
		t_abort();
		t_burn();
		t_reload();
		t_bad();
		report_and_stop();
	end
	// whole run is a few hundred cycles
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
endmodule : tb_fcl_loader
